// ==== shared/icc_pkg.sv ====
// Constants, field layout and types shared by the input capture channel
package icc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and depths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int TIMER_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  localparam int FIFO_CW = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] BUF_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int HALT_BIT = 13;
  localparam int TSEL_BIT = 7;
  localparam int CPI_LSB = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;

  // Internal status register field positions
  localparam int STAT_PRE_LSB = 0;
  localparam int STAT_IRQ_LSB = 4;
  localparam int STAT_PIN_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Capture modes
  typedef enum logic [2:0] {
    ICC_MODE_OFF    = 3'b000,
    ICC_MODE_BOTH   = 3'b001,
    ICC_MODE_FALL   = 3'b010,
    ICC_MODE_RISE   = 3'b011,
    ICC_MODE_RISE4  = 3'b100,
    ICC_MODE_RISE16 = 3'b101,
    ICC_MODE_UNUSED = 3'b110,
    ICC_MODE_WAKE   = 3'b111
  } icc_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic halt_in_idle;
    logic timer_source_select;
    logic [1:0] captures_per_irq;
    icc_mode_t capture_mode;
  } icc_ctrl_t;

  typedef struct packed {
    logic cpu_idle;
    logic cpu_sleep;
  } icc_power_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam icc_ctrl_t CTRL_RESET = '{
    halt_in_idle: 1'b0,
    timer_source_select: 1'b0,
    captures_per_irq: 2'h0,
    capture_mode: ICC_MODE_OFF
  };
  localparam logic [3:0] PRE_RESET = 4'h0;
  localparam logic [1:0] IRQ_CNT_RESET = 2'h0;
  localparam logic [3:0] PRESCALE4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE16_LAST = 4'hf;
  localparam logic [FIFO_CW-1:0] FIFO_ONE = 3'h1;

endpackage : icc_pkg

// ==== hdl/icc_fifo.sv ====
// Four-entry capture value buffer
module icc_fifo
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Fill side
  input wire logic push_i,
  input wire logic [TIMER_W-1:0] data_i,
  // Drain side
  input wire logic pop_i,
  output logic [TIMER_W-1:0] data_o,
  // Fill level
  output logic [FIFO_CW-1:0] count_o,
  output logic empty_o,
  output logic full_o
);

  logic [TIMER_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_q, wr_ptr_d;
  logic [FIFO_AW-1:0] rd_ptr_q, rd_ptr_d;
  logic [FIFO_CW-1:0] count_q, count_d;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and level update
  always_comb begin
    do_push = push_i && !full_o;
    do_pop = pop_i && !empty_o;
    wr_ptr_d = do_push ? wr_ptr_q + 2'h1 : wr_ptr_q;
    rd_ptr_d = do_pop ? rd_ptr_q + 2'h1 : rd_ptr_q;
    count_d = count_q;
    if (do_push && !do_pop) begin
      count_d = count_q + FIFO_ONE;
    end else if (do_pop && !do_push) begin
      count_d = count_q - FIFO_ONE;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // Storage
  always_ff @(posedge REF_CLK_I) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= data_i;
    end
  end

  assign data_o = mem_q[rd_ptr_q];
  assign count_o = count_q;
  assign empty_o = (count_q == '0);
  assign full_o = (count_q == FIFO_CW'(FIFO_DEPTH));

endmodule : icc_fifo

// ==== hdl/icc_capture.sv ====
// Input capture channel: edge detect, prescale, capture buffer and registers
//
// Summary of operation
// - Halt bit set stops capture in idle
// - Select bit picks second or third timer
// - Two-bit field sets captures per interrupt
// - Read-only overflow flag at bit 4
// - Read-only buffer-not-empty flag at bit 3
// - Modes 000 and 110 disable the unit
// - 010 captures falling, 011 rising edges
// - 100 every fourth, 101 every sixteenth rise
// - 001 captures both edges, interrupt every event
// - 111 rising edge interrupt only in sleep or idle
// - Unimplemented control bits read zero, ignore writes
// - Captures held in four-entry FIFO
// - Capture edge wakes device from sleep/idle; here WAKE_O follows an interrupt only, so sleep wakes only in mode 111
//
// Our own choices: the strobed register port and the placing of the registers.
module icc_capture
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // Capture pin and time bases
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire logic [TIMER_W-1:0] SECOND_TIMER_COUNT_I,
  input wire logic [TIMER_W-1:0] THIRD_TIMER_COUNT_I,
  // Power state
  input wire icc_power_t POWER_I,
  // Events
  output logic IRQ_O,
  output logic WAKE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  icc_ctrl_t ctrl_q, ctrl_d;
  logic mode_wr;
  logic ctrl_sel;
  logic buf_sel;
  logic stat_sel;
  logic pin_q, pin_d;
  logic rise;
  logic fall;
  logic low_power;
  logic run;
  logic [3:0] pre_q, pre_d;
  logic cap_evt;
  logic [TIMER_W-1:0] cap_val;
  logic push;
  logic pop;
  logic [TIMER_W-1:0] fifo_data;
  logic [FIFO_CW-1:0] fifo_count;
  logic fifo_empty;
  logic fifo_full;
  logic ovf_q, ovf_d;
  logic [1:0] irq_cnt_q, irq_cnt_d;
  logic irq_evt;
  logic wake_hit;
  logic irq_q, irq_d;
  logic wake_q, wake_d;
  logic [DATA_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] stat_rd;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    ctrl_sel = (ADDR_I == CTRL_ADDR);
    buf_sel = (ADDR_I == BUF_ADDR);
    stat_sel = (ADDR_I == STAT_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_comb begin
    ctrl_d = ctrl_q;
    mode_wr = 1'b0;
    if (WR_I && ctrl_sel) begin
      // Only implemented fields are stored
      ctrl_d.halt_in_idle = WDATA_I[HALT_BIT];
      ctrl_d.timer_source_select = WDATA_I[TSEL_BIT];
      ctrl_d.captures_per_irq = WDATA_I[CPI_LSB +: 2];
      ctrl_d.capture_mode = icc_mode_t'(WDATA_I[MODE_LSB +: 3]);
      mode_wr = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detect
  always_comb begin
    pin_d = CAPTURE_INPUT_PIN_I;
    rise = CAPTURE_INPUT_PIN_I && !pin_q;
    fall = !CAPTURE_INPUT_PIN_I && pin_q;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run gating
  always_comb begin
    low_power = POWER_I.cpu_idle || POWER_I.cpu_sleep;
    run = !POWER_I.cpu_sleep;
    if (ctrl_q.halt_in_idle && POWER_I.cpu_idle) begin
      run = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge selection and prescale
  always_comb begin
    pre_d = pre_q;
    cap_evt = 1'b0;
    if (mode_wr) begin
      pre_d = PRE_RESET;
    end else if (run) begin
      unique case (ctrl_q.capture_mode)
        ICC_MODE_OFF, ICC_MODE_UNUSED: begin
          cap_evt = 1'b0;
        end
        ICC_MODE_WAKE: begin
          cap_evt = 1'b0;
        end
        ICC_MODE_BOTH: begin
          cap_evt = rise || fall;
        end
        ICC_MODE_FALL: begin
          cap_evt = fall;
        end
        ICC_MODE_RISE: begin
          cap_evt = rise;
        end
        ICC_MODE_RISE4: begin
          if (rise) begin
            if (pre_q == PRESCALE4_LAST) begin
              pre_d = PRE_RESET;
              cap_evt = 1'b1;
            end else begin
              pre_d = pre_q + 4'h1;
            end
          end
        end
        ICC_MODE_RISE16: begin
          if (rise) begin
            if (pre_q == PRESCALE16_LAST) begin
              pre_d = PRE_RESET;
              cap_evt = 1'b1;
            end else begin
              pre_d = pre_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_q <= PRE_RESET;
    end else begin
      pre_q <= pre_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture buffer
  always_comb begin
    cap_val = ctrl_q.timer_source_select ? SECOND_TIMER_COUNT_I
                                         : THIRD_TIMER_COUNT_I;
    push = cap_evt && !fifo_full;
    pop = RD_I && buf_sel && !fifo_empty;
  end

  icc_fifo u_fifo (
    .REF_CLK_I (REF_CLK_I),
    .RST_I     (RST_I),
    .push_i    (push),
    .data_i    (cap_val),
    .pop_i     (pop),
    .data_o    (fifo_data),
    .count_o   (fifo_count),
    .empty_o   (fifo_empty),
    .full_o    (fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag
  always_comb begin
    ovf_d = ovf_q;
    if (pop && (fifo_count == FIFO_ONE)) begin
      ovf_d = 1'b0;
    end
    if (cap_evt && fifo_full) begin
      ovf_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake mode edge, lost when a control write lands with it
  always_comb begin
    wake_hit = 1'b0;
    if ((ctrl_q.capture_mode == ICC_MODE_WAKE) && low_power && rise && !mode_wr) begin
      wake_hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pacing and wake-up
  always_comb begin
    irq_cnt_d = irq_cnt_q;
    irq_evt = 1'b0;
    if (mode_wr) begin
      irq_cnt_d = IRQ_CNT_RESET;
    end else if (cap_evt) begin
      if (ctrl_q.capture_mode == ICC_MODE_BOTH) begin
        irq_evt = 1'b1;
      end else if (irq_cnt_q == ctrl_q.captures_per_irq) begin
        irq_cnt_d = IRQ_CNT_RESET;
        irq_evt = 1'b1;
      end else begin
        irq_cnt_d = irq_cnt_q + 2'h1;
      end
    end
    if (wake_hit) begin
      irq_evt = 1'b1;
    end
    irq_d = irq_evt;
    wake_d = irq_evt && low_power;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_cnt_q <= IRQ_CNT_RESET;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_cnt_q <= irq_cnt_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[HALT_BIT] = ctrl_q.halt_in_idle;
    ctrl_rd[TSEL_BIT] = ctrl_q.timer_source_select;
    ctrl_rd[CPI_LSB +: 2] = ctrl_q.captures_per_irq;
    ctrl_rd[OVF_BIT] = ovf_q;
    ctrl_rd[BNE_BIT] = !fifo_empty;
    ctrl_rd[MODE_LSB +: 3] = ctrl_q.capture_mode;
    stat_rd = '0;
    stat_rd[STAT_PRE_LSB +: 4] = pre_q;
    stat_rd[STAT_IRQ_LSB +: 2] = irq_cnt_q;
    stat_rd[STAT_PIN_BIT] = pin_q;
    rdata_d = '0;
    if (RD_I) begin
      if (ctrl_sel) begin
        rdata_d = ctrl_rd;
      end else if (buf_sel && !fifo_empty) begin
        rdata_d = fifo_data;
      end else if (stat_sel) begin
        rdata_d = stat_rd;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign RDATA_O = rdata_q;
  assign IRQ_O = irq_q;
  assign WAKE_O = wake_q;

endmodule : icc_capture

// ==== verif/icc_capture_assertions.sv ====
// Port-level checks for the input capture channel
module icc_capture_assertions
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // Pin and power
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire icc_power_t POWER_I,
  // Events
  input wire logic IRQ_O,
  input wire logic WAKE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of writable control bits
  logic [DATA_W-1:0] ctl_d;
  logic [DATA_W-1:0] ctl_q;
  logic ctl_rd;
  assign ctl_rd = RD_I && (ADDR_I == CTRL_ADDR);
  always_comb begin
    ctl_d = ctl_q;
    if (WR_I && (ADDR_I == CTRL_ADDR)) ctl_d = WDATA_I & 16'h20e7;
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) ctl_q <= '0;
    else ctl_q <= ctl_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ctrl_zero_a: assert property (ctl_rd |=> (RDATA_O & 16'hdf00) == '0)
    else $error("Unimplemented bits read nonzero");
  ctrl_echo_a: assert property (ctl_rd |=> (RDATA_O & 16'h20e7) == ctl_q)
    else $error("Control readback wrong");
  ovf_full_a: assert property (ctl_rd |=> !(RDATA_O[OVF_BIT] && !RDATA_O[BNE_BIT]))
    else $error("Overflow with empty buffer");
  irq_edge_a: assert property (
    IRQ_O |-> $past(CAPTURE_INPUT_PIN_I) != $past(CAPTURE_INPUT_PIN_I, 2))
    else $error("Interrupt without pin edge");
  off_quiet_a: assert property (
    (ctl_q[2:0] == 3'b000 || ctl_q[2:0] == 3'b110) |-> !IRQ_O)
    else $error("Interrupt while disabled");
  wake_mode_a: assert property ((ctl_q[2:0] == 3'b111 && IRQ_O) |->
    $past(POWER_I) != '0 && $past(CAPTURE_INPUT_PIN_I) && !$past(CAPTURE_INPUT_PIN_I, 2))
    else $error("Bad interrupt in wake mode");
  halt_sleep_a: assert property ((ctl_q[2:0] != 3'b111 && IRQ_O) |->
    !$past(POWER_I.cpu_sleep) && !($past(POWER_I.cpu_idle) && ctl_q[HALT_BIT]))
    else $error("Capture while halted");
  wake_src_a: assert property (WAKE_O |-> IRQ_O && $past(POWER_I) != '0)
    else $error("Wake while running");
  cover property (WAKE_O);
  cover property (IRQ_O && ctl_q[2:0] == 3'b001);
  cover property (ctl_rd ##1 RDATA_O[OVF_BIT]);
endmodule : icc_capture_assertions

// ==== verif/icc_timer_model.sv ====
// Free-running time bases seen by the capture channel
module icc_timer_model
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Time bases
  output logic [TIMER_W-1:0] second_o,
  output logic [TIMER_W-1:0] third_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Distinct rates keep the two sources apart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      second_o <= 16'h0100;
      third_o <= 16'h8000;
    end else begin
      second_o <= second_o + 16'h0001;
      third_o <= third_o + 16'h0003;
    end
  end
endmodule : icc_timer_model

// ==== verif/test_icc_capture.sv ====
// Testbench for the input capture channel
module test_icc_capture
  import icc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, pin, irq, wake;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, sec, thr, d;
  icc_power_t power;
  int n_fail = 0;
  int comparisons = 0;
  int n_irq = 0;
  int n_wake = 0;
  int bi, bw;
  logic [15:0] q[$];
  icc_capture u_icc_capture (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CAPTURE_INPUT_PIN_I(pin),
    .SECOND_TIMER_COUNT_I(sec), .THIRD_TIMER_COUNT_I(thr), .POWER_I(power), .IRQ_O(irq),
    .WAKE_O(wake));
  icc_timer_model u_icc_timer_model (.clk_i(clk), .rst_i(rst), .second_o(sec), .third_o(thr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    if (irq === 1'b1) n_irq++;
    if (wake === 1'b1) n_wake++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic pin_to(input logic v, input bit c, input bit s);
    @(posedge clk);
    pin <= v;
    #1;
    if (c && q.size() < FIFO_DEPTH) q.push_back(s ? sec : thr);
  endtask : pin_to
  task automatic pulse(input bit cr, input bit cf, input bit s);
    pin_to(1'b1, cr, s);
    pin_to(1'b0, cf, s);
  endtask : pulse
  task automatic pw(input icc_power_t p);
    @(posedge clk);
    power <= p;
  endtask : pw
  task automatic mark;
    bi = n_irq;
    bw = n_wake;
  endtask : mark
  task automatic ev_chk(input int ei, input int ew);
    repeat (3) @(posedge clk);
    #1;
    chk(16'(n_irq - bi), 16'(ei));
    chk(16'(n_wake - bw), 16'(ew));
  endtask : ev_chk
  task automatic drain;
    logic [15:0] v;
    while (q.size() > 0) begin
      rd_reg(BUF_ADDR, v);
      chk(v, q.pop_front());
    end
  endtask : drain
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    rst = 1'b1;
    {wr, rd, pin, addr, wdata, power} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(CTRL_ADDR, d);
    chk(d, 16'h0000);
    wr_reg(CTRL_ADDR, 16'hffff);
    rd_reg(CTRL_ADDR, d);
    chk(d, 16'h20e7);
    mark;
    pulse(0, 0, 0);
    pw(2'b01);
    pulse(0, 0, 0);
    pw(2'b10);
    pulse(0, 0, 0);
    ev_chk(2, 2);
    pw(2'b00);
    rd_reg(CTRL_ADDR, d);
    chk(d, 16'h20e7);
    wr_reg(CTRL_ADDR, 16'h0083);
    mark;
    repeat (5) pulse(1, 0, 1);
    ev_chk(5, 0);
    rd_reg(CTRL_ADDR, d);
    chk(d, 16'h009b);
    drain;
    rd_reg(CTRL_ADDR, d);
    chk(d, 16'h0083);
    rd_reg(BUF_ADDR, d);
    chk(d, 16'h0000);
    rd_reg(4'hc, d);
    chk(d, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr_reg(CTRL_ADDR, 16'h0002 | 16'(c << 5));
      mark;
      repeat (8) pulse(0, 1, 0);
      ev_chk(8 / (c + 1), 0);
      drain;
    end
    wr_reg(CTRL_ADDR, 16'h0061);
    mark;
    repeat (2) pulse(1, 1, 0);
    ev_chk(4, 0);
    drain;
    for (int m = 4; m < 6; m++) begin
      wr_reg(CTRL_ADDR, 16'(m));
      repeat (2) pulse(0, 0, 0);
      rd_reg(STAT_ADDR, d);
      chk(d, 16'h0002);
      wr_reg(CTRL_ADDR, 16'(m));
      rd_reg(STAT_ADDR, d);
      chk(d, 16'h0000);
      mark;
      for (int i = 1; i <= 16; i++) pulse(i % (m == 4 ? 4 : 16) == 0, 0, 0);
      ev_chk(m == 4 ? 4 : 1, 0);
      drain;
    end
    for (int m = 0; m < 7; m += 6) begin
      wr_reg(CTRL_ADDR, 16'(m));
      mark;
      pulse(0, 0, 0);
      ev_chk(0, 0);
      rd_reg(CTRL_ADDR, d);
      chk(d, 16'(m));
    end
    wr_reg(CTRL_ADDR, 16'h2003);
    pw(2'b10);
    mark;
    pulse(0, 0, 0);
    ev_chk(0, 0);
    wr_reg(CTRL_ADDR, 16'h0003);
    mark;
    pulse(1, 0, 0);
    ev_chk(1, 1);
    pw(2'b01);
    mark;
    pulse(0, 0, 0);
    ev_chk(0, 0);
    pw(2'b00);
    drain;
    end_sim;
  end
endmodule : test_icc_capture
bind icc_capture icc_capture_assertions u_icc_capture_assertions (.REF_CLK_I(REF_CLK_I),
  .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .CAPTURE_INPUT_PIN_I(CAPTURE_INPUT_PIN_I), .POWER_I(POWER_I),
  .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));
